// ### include/iasc_defs.svh
// Offsets, field positions, reset values and constants of the datapath
`ifndef IASC_DEFS_SVH
`define IASC_DEFS_SVH

`define IASC_XLEN            32
`define IASC_IMM_W           12
`define IASC_ADDR_W          12
`define IASC_OFS_CTRL        12'h000
`define IASC_OFS_FLAGS       12'h004
`define IASC_OFS_COUNT       12'h008
`define IASC_CTRL_EN_BIT     0
`define IASC_CTRL_CLR_BIT    1
`define IASC_FLAG_V_BIT      0
`define IASC_FLAG_C_BIT      1
`define IASC_FLAG_Z_BIT      2
`define IASC_FLAG_N_BIT      3
`define IASC_CTRL_RST        1'b1
`define IASC_FLAGS_RST       4'h0
`define IASC_COUNT_RST       32'h0000_0000
`define IASC_BASE_ALIGN_MASK 32'hFFFF_FFFC
`define IASC_BRANCH_MASK     32'hFFFF_FFFE
`define IASC_LZC_ALL_ZERO    6'h20
`define IASC_SHIFT_FULL      8'h20
`define IASC_IMM_ZERO_EXT    20'h0_0000

`endif

// ### include/iasc_pkg.sv
// Operation codes and request and answer carriers of the datapath
package iasc_pkg;
	`include "iasc_defs.svh"

	typedef enum logic [4:0] {
		sum_op,
		sum_carry_op,
		difference_op,
		minus_with_borrow_op,
		reverse_difference_op,
		wide_immediate_sum,
		wide_immediate_difference,
		conjunction_op,
		bitwise_disjunction_op,
		exclusive_disjunction_op,
		bit_clear_op,
		or_not_op,
		shift_right_arith,
		shift_left_logical,
		shift_right_logical,
		rotate_right_op,
		rotate_extend_op,
		leading_zero_count_op,
		compare_op,
		compare_negative_op
	} iasc_op_t;

	typedef struct packed {
		iasc_op_t                 op;
		logic [`IASC_XLEN-1:0]    first_operand_reg;
		logic [`IASC_XLEN-1:0]    flex_second_operand;
		logic [`IASC_IMM_W-1:0]   twelve_bit_immediate;
		logic                     use_imm;
		logic                     first_is_program_counter;
		logic                     dest_is_program_counter;
		logic                     set_flags;
		logic [`IASC_XLEN-1:0]    source_reg;
		logic [`IASC_XLEN-1:0]    shift_amount_reg;
		logic [5:0]               shift_imm;
		logic                     shift_by_reg;
		logic                     op2_carry;
		logic                     op2_carry_valid;
	} iasc_req_t;

	typedef struct packed {
		logic [`IASC_XLEN-1:0]    result;
		logic                     write_dest;
		logic                     branch;
		logic [`IASC_XLEN-1:0]    branch_addr;
	} iasc_rsp_t;
endpackage

// ### hw/iasc_alu_top.sv
// Integer sum, logic, shift, leading-zero and compare datapath with APB
// Notes on behaviour
// - Sum adds flexible operand or 12-bit immediate to first operand.
// - Sum-with-carry adds both operands plus the current carry flag.
// - Difference subtracts flexible operand or immediate from first operand.
// - Minus-with-borrow subtracts, then takes one more when carry is clear.
// - Reverse difference subtracts first operand from flexible operand.
// - Wide-immediate sum and difference act as their immediate forms.
// - Program counter as operand has its two low bits forced to zero.
// - Sum writing program counter branches with bit zero forced low.
// - Flag suffix on arithmetic updates negative, zero, carry and overflow.
// - Conjunction, exclusive-or and disjunction combine operands bit by bit.
// - Bit-clear ands first operand with complement of flexible operand.
// - Or-not ors first operand with complement of flexible operand.
// - Logic with flags sets N and Z, carry from op2_carry when op2_carry_valid, else kept, keeps V.
// - Register shift amount uses only its low byte, zero to 255.
// - Immediate: arith right 1-32, left 0-31, right 1-32, rotate 1-31.
// - Rotate-with-extend shifts right by one, carry fills top bit.
// - Shifts write only the destination; the source stays unchanged.
// - Shift flags: N, Z, carry is last bit out unless amount zero.
// - Leading-zero count gives 32 for zero and 0 when top bit set.
// - Leading-zero count never touches any condition flag.
// - Compare subtracts, always sets all four flags, discards the result.
// - Compare-negative adds, always sets all four flags, writes nothing.
`timescale 1ns/1ps
`include "iasc_defs.svh"

module iasc_alu_top
(
	input  wire logic                    ref_clk,
	input  wire logic                    reset_n,
	input  wire logic                    req_valid,
	input  wire iasc_pkg::iasc_req_t     req,
	output logic                         rsp_valid,
	output iasc_pkg::iasc_rsp_t          rsp,
	output logic [3:0]                   flags,
	input  wire logic [`IASC_ADDR_W-1:0] paddr,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [31:0]             pwdata,
	input  wire logic [3:0]              pstrb,
	output logic [31:0]                  prdata,
	output logic                         pready,
	output logic                         pslverr
);

	// ****************************************************************
	// Operation classes and operand selection
	// ****************************************************************
	iasc_pkg::iasc_op_t op;
	logic [31:0]        op_a;
	logic [31:0]        op_b;
	logic               use_imm_eff;
	logic               is_add;
	logic               is_adc;
	logic               is_sub;
	logic               is_brw;
	logic               is_rev;
	logic               is_arith;
	logic               is_logic;
	logic               is_shift;
	logic               is_lzc;
	logic               is_test;
	logic               flag_c;
	logic               ctrl_en_q;
	logic               accept;

	assign op          = req.op;
	assign accept      = req_valid & ctrl_en_q;
	assign is_add      = (op == iasc_pkg::sum_op) |
	                     (op == iasc_pkg::wide_immediate_sum) |
	                     (op == iasc_pkg::compare_negative_op);
	assign is_adc      = (op == iasc_pkg::sum_carry_op);
	assign is_sub      = (op == iasc_pkg::difference_op) |
	                     (op == iasc_pkg::wide_immediate_difference) |
	                     (op == iasc_pkg::compare_op);
	assign is_brw      = (op == iasc_pkg::minus_with_borrow_op);
	assign is_rev      = (op == iasc_pkg::reverse_difference_op);
	assign is_arith    = is_add | is_adc | is_sub | is_brw | is_rev;
	assign is_logic    = (op == iasc_pkg::conjunction_op) |
	                     (op == iasc_pkg::bitwise_disjunction_op) |
	                     (op == iasc_pkg::exclusive_disjunction_op) |
	                     (op == iasc_pkg::bit_clear_op) |
	                     (op == iasc_pkg::or_not_op);
	assign is_shift    = (op == iasc_pkg::shift_right_arith) |
	                     (op == iasc_pkg::shift_left_logical) |
	                     (op == iasc_pkg::shift_right_logical) |
	                     (op == iasc_pkg::rotate_right_op) |
	                     (op == iasc_pkg::rotate_extend_op);
	assign is_lzc      = (op == iasc_pkg::leading_zero_count_op);
	assign is_test     = (op == iasc_pkg::compare_op) |
	                     (op == iasc_pkg::compare_negative_op);

	// Wide forms always take the immediate path
	assign use_imm_eff = req.use_imm |
	                     (op == iasc_pkg::wide_immediate_sum) |
	                     (op == iasc_pkg::wide_immediate_difference);
	// Immediate is zero-extended; the decoder never sends a signed one
	assign op_b = use_imm_eff ?
	              {`IASC_IMM_ZERO_EXT, req.twelve_bit_immediate} :
	              req.flex_second_operand;
	assign op_a = req.first_is_program_counter ?
	              (req.first_operand_reg & `IASC_BASE_ALIGN_MASK) :
	              req.first_operand_reg;

	// ****************************************************************
	// Adder shared by every sum, difference and compare
	// ****************************************************************
	logic [31:0] add_x;
	logic [31:0] add_y;
	logic        add_cin;
	logic [32:0] add_sum;
	logic        add_v;

	// One adder: subtraction is x + ~y + 1, borrow shows as carry clear
	assign add_x   = is_rev ? op_b : op_a;
	assign add_y   = is_rev ? ~op_a :
	                 (is_sub | is_brw) ? ~op_b : op_b;
	assign add_cin = (is_adc | is_brw) ? flag_c :
	                 (is_sub | is_rev) ? 1'b1 : 1'b0;
	assign add_sum = {1'b0, add_x} + {1'b0, add_y} + {32'h0000_0000, add_cin};
	assign add_v   = (add_x[31] == add_y[31]) &
	                 (add_sum[31] != add_x[31]);

	// ****************************************************************
	// Bitwise logic
	// ****************************************************************
	logic [31:0] logic_res;

	always_comb
	begin
		unique case (op)
			iasc_pkg::bitwise_disjunction_op:   logic_res = op_a | op_b;
			iasc_pkg::exclusive_disjunction_op: logic_res = op_a ^ op_b;
			iasc_pkg::bit_clear_op:             logic_res = op_a & ~op_b;
			iasc_pkg::or_not_op:                logic_res = op_a | ~op_b;
			default:                            logic_res = op_a & op_b;
		endcase
	end

	// ****************************************************************
	// Shifter and rotator
	// ****************************************************************
	logic [7:0]  sh_amt;
	logic [4:0]  rot_amt;
	logic [31:0] sh_src;
	logic [31:0] sh_res;
	logic        sh_c;
	logic        sh_c_upd;
	logic [32:0] sh_left;
	logic [32:0] sh_right;
	logic [32:0] sh_arith;
	logic [31:0] rot_res;

	// Only the low byte of the amount register counts
	assign sh_amt   = req.shift_by_reg ? req.shift_amount_reg[7:0] :
	                  {2'b00, req.shift_imm};
	assign rot_amt  = sh_amt[4:0];
	assign sh_src   = req.source_reg;
	assign sh_left  = {1'b0, sh_src} << sh_amt;
	assign sh_right = {sh_src, 1'b0} >> sh_amt;
	assign sh_arith = 33'($signed({sh_src, 1'b0}) >>> sh_amt);
	assign rot_res  = (sh_src >> rot_amt) | (sh_src << (6'd32 - {1'b0, rot_amt}));
	assign sh_c_upd = (sh_amt != 8'h00) |
	                  (op == iasc_pkg::rotate_extend_op);

	always_comb
	begin
		sh_res = sh_src;
		sh_c   = flag_c;
		unique case (op)
			iasc_pkg::shift_left_logical:
			begin
				sh_res = (sh_amt > `IASC_SHIFT_FULL) ? 32'h0000_0000 : sh_left[31:0];
				sh_c   = (sh_amt > `IASC_SHIFT_FULL) ? 1'b0 : sh_left[32];
			end
			iasc_pkg::shift_right_logical:
			begin
				sh_res = (sh_amt > `IASC_SHIFT_FULL) ? 32'h0000_0000 : sh_right[32:1];
				sh_c   = (sh_amt > `IASC_SHIFT_FULL) ? 1'b0 : sh_right[0];
			end
			iasc_pkg::shift_right_arith:
			begin
				// From 32 on the sign bit fills the word and is also the carry
				sh_res = (sh_amt >= `IASC_SHIFT_FULL) ? {32{sh_src[31]}} :
				         sh_arith[32:1];
				sh_c   = (sh_amt >= `IASC_SHIFT_FULL) ? sh_src[31] : sh_arith[0];
			end
			iasc_pkg::rotate_right_op:
			begin
				sh_res = rot_res;
				sh_c   = rot_res[31];
			end
			iasc_pkg::rotate_extend_op:
			begin
				sh_res = {flag_c, sh_src[31:1]};
				sh_c   = sh_src[0];
			end
			default:
			begin
				sh_res = sh_src;
				sh_c   = flag_c;
			end
		endcase
		if (!sh_c_upd)
		begin
			sh_res = sh_src;
			sh_c   = flag_c;
		end
	end

	// ****************************************************************
	// Leading-zero count
	// ****************************************************************
	logic [5:0] lzc_res;
	logic [31:0] lzc_hit;

	// Per bit: set where this bit is the highest one set
	for (genvar i = 0; i < 32; i++)
	begin : g_lzc
		if (i == 31)
		begin : g_top
			assign lzc_hit[i] = sh_src[i];
		end
		else
		begin : g_rest
			assign lzc_hit[i] = sh_src[i] & ~|sh_src[31:i+1];
		end
	end

	always_comb
	begin
		lzc_res = `IASC_LZC_ALL_ZERO;
		for (int k = 0; k < 32; k++)
		begin
			if (lzc_hit[k])
			begin
				lzc_res = 6'(31 - k);
			end
		end
	end

	// ****************************************************************
	// Result, branch and flag selection
	// ****************************************************************
	logic [31:0] res;
	logic        is_branch;
	logic        flag_upd;
	logic [3:0]  flags_new;
	logic        new_c;
	logic        new_v;

	assign res       = is_arith ? add_sum[31:0] :
	                   is_logic ? logic_res :
	                   is_shift ? sh_res :
	                   {26'h000_0000, lzc_res};
	assign is_branch = req.dest_is_program_counter & (is_add | is_adc) &
	                   ~is_test;
	assign flag_upd  = accept & ~is_lzc &
	                   (is_test | req.set_flags);
	assign new_c     = is_arith ? add_sum[32] :
	                   is_shift ? sh_c :
	                   (req.op2_carry_valid ? req.op2_carry : flag_c);
	assign new_v     = is_arith ? add_v : flags[`IASC_FLAG_V_BIT];
	assign flags_new = {res[31], res == 32'h0000_0000, new_c, new_v};

	// ****************************************************************
	// Answer registers
	// ****************************************************************
	iasc_pkg::iasc_rsp_t rsp_d;

	assign rsp_d.result      = res;
	// Only the destination is written; nothing flows back to the source
	assign rsp_d.write_dest  = ~is_test & ~is_branch;
	assign rsp_d.branch      = is_branch;
	assign rsp_d.branch_addr = res & `IASC_BRANCH_MASK;

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rsp_valid <= 1'b0;
			rsp       <= '0;
		end
		else
		begin
			rsp_valid <= accept;
			if (accept)
			begin
				rsp <= rsp_d;
			end
		end
	end

	// ****************************************************************
	// APB slave: control, flags and operation count
	// ****************************************************************
	logic        hit_ctrl;
	logic        hit_flags;
	logic        hit_count;
	logic        hit_any;
	logic        apb_wait;
	logic        apb_fire;
	logic        wr_lane0;
	logic [31:0] rd_mux;
	logic [31:0] count_q;
	logic        clr_cnt;
	logic [3:0]  flags_d;

	assign hit_ctrl  = (paddr == `IASC_OFS_CTRL);
	assign hit_flags = (paddr == `IASC_OFS_FLAGS);
	assign hit_count = (paddr == `IASC_OFS_COUNT);
	assign hit_any   = hit_ctrl | hit_flags | hit_count;
	// One wait state: pready rises in the second access cycle
	assign apb_wait  = psel & penable & ~pready;
	assign apb_fire  = psel & penable & pready;
	assign wr_lane0  = apb_fire & pwrite & pstrb[0];
	assign clr_cnt   = wr_lane0 & hit_ctrl & pwdata[`IASC_CTRL_CLR_BIT];
	assign rd_mux    = hit_ctrl  ? {31'h0000_0000, ctrl_en_q} :
	                   hit_flags ? {28'h000_0000, flags} :
	                   hit_count ? count_q : 32'h0000_0000;
	assign flag_c    = flags[`IASC_FLAG_C_BIT];
	// A datapath update in the same cycle wins over a software write
	assign flags_d   = flag_upd ? flags_new :
	                   (wr_lane0 & hit_flags) ? pwdata[3:0] : flags;

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= apb_wait;
			pslverr <= apb_wait & ~hit_any;
			prdata  <= (apb_wait & ~pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ctrl_en_q <= `IASC_CTRL_RST;
			flags     <= `IASC_FLAGS_RST;
			count_q   <= `IASC_COUNT_RST;
		end
		else
		begin
			flags   <= flags_d;
			count_q <= (clr_cnt ? 32'h0000_0000 : count_q) +
			           {31'h0000_0000, accept};
			if (wr_lane0 & hit_ctrl)
			begin
				ctrl_en_q <= pwdata[`IASC_CTRL_EN_BIT];
			end
		end
	end

	// ****************************************************************
	// Assertions and covers
	// ****************************************************************
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	logic [31:0] chk_a;
	logic [31:0] chk_b;
	assign chk_a = req.first_operand_reg;
	assign chk_b = req.flex_second_operand;

	sum_result_a: assert property (
		accept && op == iasc_pkg::sum_op && !req.use_imm &&
		!req.first_is_program_counter
		|=> rsp_valid && rsp.result == $past(chk_a) + $past(chk_b))
		else $error("sum result wrong");

	borrow_sub_a: assert property (
		accept && op == iasc_pkg::minus_with_borrow_op &&
		!req.first_is_program_counter && !flag_c
		|=> rsp.result == $past(chk_a) - $past(chk_b) - 32'h0000_0001)
		else $error("borrow difference wrong");

	reverse_diff_a: assert property (
		accept && op == iasc_pkg::reverse_difference_op &&
		!req.first_is_program_counter
		|=> rsp.result == $past(chk_b) - $past(chk_a))
		else $error("reverse difference wrong");

	base_align_a: assert property (
		accept && is_add && !is_test && use_imm_eff &&
		req.first_is_program_counter
		|=> rsp.result[1:0] == $past(req.twelve_bit_immediate[1:0]))
		else $error("program counter not aligned");

	branch_addr_a: assert property (
		rsp_valid && rsp.branch |-> !rsp.branch_addr[0] && !rsp.write_dest)
		else $error("branch address bit zero set");

	clear_result_a: assert property (
		accept && op == iasc_pkg::bit_clear_op
		|=> (rsp.result & $past(chk_b)) == 32'h0000_0000)
		else $error("bit clear left bits set");

	logic_keep_v_a: assert property (
		accept && is_logic && req.set_flags
		|=> flags[`IASC_FLAG_V_BIT] == $past(flags[`IASC_FLAG_V_BIT]))
		else $error("logic changed overflow");

	extend_shape_a: assert property (
		accept && op == iasc_pkg::rotate_extend_op
		|=> rsp.result == {$past(flag_c), $past(sh_src[31:1])})
		else $error("rotate extend wrong");

	zero_shift_a: assert property (
		accept && is_shift && op != iasc_pkg::rotate_extend_op &&
		sh_amt == 8'h00 && req.set_flags
		|=> rsp.result == $past(sh_src) &&
		    flags[`IASC_FLAG_C_BIT] == $past(flag_c))
		else $error("zero shift moved carry");

	lzc_zero_a: assert property (
		accept && is_lzc && sh_src == 32'h0000_0000
		|=> rsp.result == 32'h0000_0020)
		else $error("leading zeros of zero not 32");

	lzc_flags_a: assert property (
		accept && is_lzc && !(wr_lane0 && hit_flags) |=> $stable(flags))
		else $error("leading zero count changed flags");

	compare_flags_a: assert property (
		accept && op == iasc_pkg::compare_op && chk_a == chk_b &&
		!req.first_is_program_counter && !req.use_imm
		|=> flags[`IASC_FLAG_Z_BIT] && flags[`IASC_FLAG_C_BIT] &&
		    !rsp.write_dest)
		else $error("equal compare flags wrong");

	apb_answer_a: assert property (
		psel && !penable ##1 psel && penable |-> !pready ##1 pready)
		else $error("APB answer timing wrong");

	add_cover_c: cover property (
		accept && is_adc && flag_c ##1 rsp_valid);
	branch_cover_c: cover property (
		accept && is_branch ##1 rsp.branch);
	shift_cover_c: cover property (
		accept && op == iasc_pkg::shift_right_arith &&
		sh_amt == `IASC_SHIFT_FULL);
	apb_cover_c: cover property (
		apb_fire && pwrite && hit_ctrl);

endmodule

// ### testbench/iasc_decoder_model.sv
// Decoder and register-file model on the far side of the datapath
`timescale 1ns/1ps

module iasc_decoder_model
(
	input  wire logic                ref_clk,
	input  wire logic                reset_n,
	input  wire logic                cmd_valid,
	input  wire iasc_pkg::iasc_req_t cmd,
	output logic                     req_valid,
	output iasc_pkg::iasc_req_t      req,
	input  wire logic                rsp_valid,
	input  wire iasc_pkg::iasc_rsp_t rsp,
	output logic [31:0]              dest_q
);
	// ****************************************
	// Issue and write-back
	// ****************************************
	// Idle operands flip every cycle so stale values never pass for valid
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			req_valid <= 1'b0;
			req       <= '0;
			dest_q    <= 32'h0000_0000;
		end
		else
		begin
			req_valid <= cmd_valid;
			// Immediate field is 12 bits, so always unsigned in range
			req       <= cmd_valid ? cmd : iasc_pkg::iasc_req_t'(~req);
			if (rsp_valid && rsp.write_dest)
				dest_q <= rsp.result;
		end
	end
endmodule

// ### testbench/tb_top.sv
// Self-checking bench for the integer datapath
`timescale 1ns/1ps

module tb_top;
	logic                ref_clk;
	logic                reset_n;
	logic                cmd_valid;
	iasc_pkg::iasc_req_t cmd;
	logic                req_valid;
	iasc_pkg::iasc_req_t req;
	logic                rsp_valid;
	iasc_pkg::iasc_rsp_t rsp;
	logic [3:0]          flags;
	logic [11:0]         paddr;
	logic                psel;
	logic                penable;
	logic                pwrite;
	logic [31:0]         pwdata;
	logic [31:0]         prdata;
	logic                pready;
	logic                pslverr;
	logic [31:0]         dest_q;
	int                  fails;
	int                  checks_done;
	int                  cyc;
	iasc_pkg::iasc_req_t r;

	iasc_alu_top iasc_alu_top_i (.ref_clk(ref_clk), .reset_n(reset_n),
		.req_valid(req_valid), .req(req), .rsp_valid(rsp_valid),
		.rsp(rsp), .flags(flags), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.pstrb(4'hF), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	iasc_decoder_model iasc_decoder_model_i (.ref_clk(ref_clk),
		.reset_n(reset_n), .cmd_valid(cmd_valid), .cmd(cmd),
		.req_valid(req_valid), .req(req), .rsp_valid(rsp_valid),
		.rsp(rsp), .dest_q(dest_q));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e,
		input string m);
		checks_done++;
		if (g !== e)
		begin
			fails++;
			$display("wrong value at %0t: %s %h not %h", $time, m, g, e);
		end
	endtask

	// Request is held until the edge at which pready is seen high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [31:0] eq, input logic ee);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		#1;
		while (pready !== 1'b1 && n < 20)
		begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		chk(32'(pready), 32'h1, "pready");
		chk(32'(pslverr), 32'(ee), "pslverr");
		if (!w)
			chk(prdata, eq, "prdata");
		@(posedge ref_clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic iasc_pkg::iasc_req_t mk(iasc_pkg::iasc_op_t o,
		logic [31:0] a, logic [31:0] b, logic s);
		iasc_pkg::iasc_req_t q;
		q = '0;
		q.op = o;
		q.first_operand_reg = a;
		q.source_reg = a;
		q.flex_second_operand = b;
		q.shift_amount_reg = b;
		q.shift_imm = b[5:0];
		q.set_flags = s;
		return q;
	endfunction

	// Result is only compared where the destination is written
	task automatic go(input logic acc, input logic [31:0] er,
		input logic ew, input logic [3:0] ef);
		logic [31:0] prev;
		int n;
		prev = dest_q;
		n = 0;
		@(posedge ref_clk);
		cmd <= r;
		cmd_valid <= 1'b1;
		@(posedge ref_clk);
		cmd_valid <= 1'b0;
		#1;
		while (rsp_valid !== 1'b1 && n < 8)
		begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		chk(32'(rsp_valid), 32'(acc), "answer");
		if (acc)
			chk(32'(rsp.write_dest), 32'(ew), "write_dest");
		if (acc && ew)
			chk(rsp.result, er, "result");
		chk(32'(flags), 32'(ef), "flags");
		@(posedge ref_clk);
		#1;
		chk(dest_q, ew ? er : prev, "dest");
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs;
		apb(0, 12'h000, 0, 32'h0000_0001, 0);
		apb(0, 12'h004, 0, 32'h0000_0000, 0);
		apb(0, 12'h008, 0, 32'h0000_0000, 0);
		apb(0, 12'h00C, 0, 32'h0000_0000, 1);
		apb(1, 12'h00C, 32'h0000_FFFF, 0, 1);
		$display("test regs done");
	endtask

	task automatic t_arith;
		r = mk(iasc_pkg::sum_op, 32'h7FFF_FFFF, 1, 1);
		go(1, 32'h8000_0000, 1, 4'h9);
		r = mk(iasc_pkg::sum_op, 1, 32'h0000_DEAD, 0);
		r.use_imm = 1'b1;
		r.twelve_bit_immediate = 12'hFFF;
		go(1, 32'h0000_1000, 1, 4'h9);
		r = mk(iasc_pkg::wide_immediate_sum, 2, 32'h0000_5555, 0);
		r.twelve_bit_immediate = 12'h010;
		go(1, 32'h0000_0012, 1, 4'h9);
		r = mk(iasc_pkg::wide_immediate_difference, 32'h1000, 7, 0);
		r.twelve_bit_immediate = 12'h001;
		go(1, 32'h0000_0FFF, 1, 4'h9);
		r = mk(iasc_pkg::difference_op, 5, 5, 1);
		go(1, 32'h0000_0000, 1, 4'h6);
		r = mk(iasc_pkg::minus_with_borrow_op, 10, 3, 0);
		go(1, 32'h0000_0007, 1, 4'h6);
		r = mk(iasc_pkg::difference_op, 0, 1, 1);
		go(1, 32'hFFFF_FFFF, 1, 4'h8);
		r = mk(iasc_pkg::minus_with_borrow_op, 10, 3, 0);
		go(1, 32'h0000_0006, 1, 4'h8);
		apb(1, 12'h004, 32'h0000_0002, 0, 0);
		r = mk(iasc_pkg::sum_carry_op, 1, 2, 1);
		go(1, 32'h0000_0004, 1, 4'h0);
		r = mk(iasc_pkg::reverse_difference_op, 3, 10, 1);
		go(1, 32'h0000_0007, 1, 4'h2);
		r = mk(iasc_pkg::sum_op, 32'h0000_1003, 0, 0);
		r.use_imm = 1'b1;
		r.twelve_bit_immediate = 12'h004;
		r.first_is_program_counter = 1'b1;
		go(1, 32'h0000_1004, 1, 4'h2);
		r = mk(iasc_pkg::sum_op, 32'h0000_0100, 5, 0);
		r.dest_is_program_counter = 1'b1;
		go(1, 0, 0, 4'h2);
		chk(32'(rsp.branch), 32'h1, "branch");
		chk(rsp.branch_addr, 32'h0000_0104, "target");
		$display("test arith done");
	endtask

	task automatic t_logic;
		logic [31:0] a;
		logic [31:0] b;
		a = 32'hF0F0_1234;
		b = 32'h0FF0_00FF;
		apb(1, 12'h004, 32'h0000_0001, 0, 0);
		r = mk(iasc_pkg::conjunction_op, a, b, 0);
		go(1, 32'h00F0_0034, 1, 4'h1);
		r = mk(iasc_pkg::bitwise_disjunction_op, a, b, 0);
		go(1, 32'hFFF0_12FF, 1, 4'h1);
		r = mk(iasc_pkg::exclusive_disjunction_op, a, b, 0);
		go(1, 32'hFF00_12CB, 1, 4'h1);
		r = mk(iasc_pkg::bit_clear_op, a, b, 0);
		go(1, 32'hF000_1200, 1, 4'h1);
		r = mk(iasc_pkg::or_not_op, a, b, 0);
		go(1, 32'hF0FF_FF34, 1, 4'h1);
		r = mk(iasc_pkg::conjunction_op, 32'h8000_0000, 32'h8000_0001, 1);
		r.op2_carry = 1'b1;
		r.op2_carry_valid = 1'b1;
		go(1, 32'h8000_0000, 1, 4'hB);
		apb(0, 12'h004, 0, 32'h0000_000B, 0);
		r = mk(iasc_pkg::bit_clear_op, 32'hFF, 32'hFF, 1);
		go(1, 32'h0000_0000, 1, 4'h7);
		$display("test logic done");
	endtask

	// Write to the destination only; the source is the bench's own value
	task automatic t_shift;
		r = mk(iasc_pkg::rotate_extend_op, 3, 5, 1);
		go(1, 32'h8000_0001, 1, 4'hB);
		r = mk(iasc_pkg::shift_right_arith, 32'h8000_0000, 32, 1);
		go(1, 32'hFFFF_FFFF, 1, 4'hB);
		r = mk(iasc_pkg::shift_right_logical, 32'h8000_0000, 32, 1);
		go(1, 32'h0000_0000, 1, 4'h7);
		r = mk(iasc_pkg::shift_left_logical, 32'h1000_0001, 32'h104, 1);
		r.shift_by_reg = 1'b1;
		r.shift_imm = 6'h00;
		go(1, 32'h0000_0010, 1, 4'h3);
		r = mk(iasc_pkg::rotate_right_op, 32'h1234_5678, 8, 1);
		go(1, 32'h7812_3456, 1, 4'h1);
		r = mk(iasc_pkg::shift_left_logical, 32'h8000_0000, 0, 1);
		go(1, 32'h8000_0000, 1, 4'h9);
		r = mk(iasc_pkg::shift_right_logical, 3, 1, 1);
		go(1, 32'h0000_0001, 1, 4'h3);
		$display("test shift done");
	endtask

	task automatic t_count_test;
		r = mk(iasc_pkg::leading_zero_count_op, 0, 0, 1);
		go(1, 32'h0000_0020, 1, 4'h3);
		r = mk(iasc_pkg::leading_zero_count_op, 32'h8000_0000, 0, 1);
		go(1, 32'h0000_0000, 1, 4'h3);
		r = mk(iasc_pkg::leading_zero_count_op, 32'h0001_0000, 0, 1);
		go(1, 32'h0000_000F, 1, 4'h3);
		r = mk(iasc_pkg::compare_op, 5, 7, 0);
		go(1, 0, 0, 4'h8);
		r = mk(iasc_pkg::compare_op, 9, 9, 0);
		go(1, 0, 0, 4'h6);
		r = mk(iasc_pkg::compare_negative_op, 32'hFFFF_FFFF, 1, 0);
		go(1, 0, 0, 4'h6);
		r = mk(iasc_pkg::compare_op, 32'h8000_0000, 1, 0);
		go(1, 0, 0, 4'h3);
		$display("test count and compare done");
	endtask

	// Disabled datapath drops requests with no trace in flags or count
	task automatic t_refuse;
		apb(1, 12'h000, 32'h0000_0003, 0, 0);
		apb(0, 12'h008, 0, 32'h0000_0000, 0);
		r = mk(iasc_pkg::sum_op, 1, 1, 0);
		go(1, 32'h0000_0002, 1, 4'h3);
		go(1, 32'h0000_0002, 1, 4'h3);
		apb(0, 12'h008, 0, 32'h0000_0002, 0);
		apb(1, 12'h000, 32'h0000_0000, 0, 0);
		r = mk(iasc_pkg::sum_op, 7, 7, 1);
		go(0, 0, 0, 4'h3);
		apb(0, 12'h008, 0, 32'h0000_0002, 0);
		apb(0, 12'h000, 0, 32'h0000_0000, 0);
		apb(1, 12'h000, 32'h0000_0001, 0, 0);
		$display("test refuse done");
	endtask

	// ****************************************
	// Clock, timeout and main sequence
	// ****************************************
	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fails++;
			complete_run();
		end
	end

	initial
	begin
		reset_n = 1'b0;
		cmd_valid = 1'b0;
		cmd = '0;
		r = '0;
		paddr = 12'h000;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = 32'h0000_0000;
		fails = 0;
		checks_done = 0;
		cyc = 0;
		repeat (6) @(posedge ref_clk);
		reset_n <= 1'b1;
		t_regs();
		t_arith();
		t_logic();
		t_shift();
		t_count_test();
		t_refuse();
		complete_run();
	end
endmodule
